// File: batch_decoder.sv
// decodes the arbitration batch code into a transfer count
`timescale 1ns/10ps
`include "dma_ctl_cfg.svh"
module batch_decoder (
   // code in
   input wire logic [3:0] arbitration_batch_code_i,
   // batch size out, 1 to 1024
   output logic [10:0] batch_size_o
);
   // codes above nine saturate at 1024, never cutting a cycle
   wire logic [3:0] log_size = (arbitration_batch_code_i > `ARB_CODE_MAX) ?
      `ARB_LOG_MAX : arbitration_batch_code_i;
   assign batch_size_o = 11'h001 << log_size;
endmodule // batch_decoder

// File: dma_channel_control_word.sv
// one dma channel: control words, batch arbitration, write-back of count
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "dma_ctl_cfg.svh"
// Summary of operation
// - batch code 9 means 512 transfers; codes a to f mean 1024
// - item count field bits 13:4 holds items minus one
// - count units are items of configured size, not bytes
// - count written back before each arbitration shows items outstanding
// - burst select bit 3 forces burst for last peripheral gather transfer, sets flag
// - burst select clear and short remainder: finish with single transfers
// - mode zero is stopped or invalid; no transfers happen (checked only at a start and while basic mode waits; a running cycle goes on)
// - basic mode needs a fresh request before each arbitration
// - auto mode: one request moves the whole count
// - ping-pong swaps structures after each cycle run in ping-pong mode; the next cycle waits for a new request
// - batch codes 0 to 8 give 1 to 256 transfers
module dma_channel_control_word (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [31:0] reg_rdata_o,
   // peripheral request pin
   input wire logic dma_request_i,
   // transfer side
   output logic item_move_o,
   output logic burst_move_o,
   output logic burst_only_flag_o,
   output logic cycle_done_o
);
   // ---------------------------------------------------------------
   // request synchroniser
   // ---------------------------------------------------------------
   logic req_meta_q, req_sync_q, req_prev_q;
   always_ff @(posedge clk_i) begin
      req_meta_q <= reset_n_i ? dma_request_i : 1'b0;
      req_sync_q <= reset_n_i ? req_meta_q : 1'b0;
      req_prev_q <= reset_n_i ? req_sync_q : 1'b0;
   end
   wire logic req_rise = req_sync_q & ~req_prev_q;

   // ---------------------------------------------------------------
   // control structures and registers
   // ---------------------------------------------------------------
   logic [31:0] ctl_q [2];
   logic use_alt_q, enable_q, soft_req_q, burst_flag_q;
   logic [10:0] left_q, in_batch_q;
   logic [31:0] rdata_q;
   dma_ctl_pkg::engine_state_e state_q;

   // selected structure fields
   wire logic [31:0] cur_ctl = ctl_q[use_alt_q];
   wire logic [2:0] cur_mode_raw = cur_ctl[`MODE_MSB:`MODE_LSB];
   wire dma_ctl_pkg::cycle_mode_e cur_mode = dma_ctl_pkg::cycle_mode_e'(cur_mode_raw);
   wire logic [9:0] count_field = cur_ctl[`COUNT_MSB:`COUNT_LSB];
   wire logic burst_sel = cur_ctl[`BURST_SEL_BIT];
   wire logic [3:0] arb_code = cur_ctl[`ARB_MSB:`ARB_LSB];
   logic [10:0] batch_size;
   batch_decoder u_batch (
      .arbitration_batch_code_i(arb_code),
      .batch_size_o(batch_size)
   );

   // decode of the register port
   wire logic wr_pri = reg_write_i && reg_addr_i == `OFS_PRI_CTL;
   wire logic wr_alt = reg_write_i && reg_addr_i == `OFS_ALT_CTL;
   wire logic wr_chan = reg_write_i && reg_addr_i == `OFS_CHAN_CTL;
   wire logic is_per_sg = cur_mode == dma_ctl_pkg::MODE_PER_SG ||
      cur_mode == dma_ctl_pkg::MODE_ALT_PER_SG;
   wire logic last_piece = left_q < batch_size; // remainder shorter than a batch
   wire logic moving = state_q == dma_ctl_pkg::ST_MOVE;
   wire logic batch_end = moving && (in_batch_q == 11'h001 || left_q == 11'h001);
   wire logic cycle_end = moving && left_q == 11'h001;
   wire logic mode_valid = cur_mode != dma_ctl_pkg::MODE_STOP;
   // auto mode accepts a software request as well as the pin
   wire logic start_req = req_rise | soft_req_q;
   // left_q still counts the item moving now, so remaining minus one is left_q minus two;
   // at cycle end this wraps to all ones, harmless once the mode field is cleared
   wire logic [9:0] wb_count = 10'(left_q - 11'h002);

   // ---------------------------------------------------------------
   // engine state
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_q <= dma_ctl_pkg::ST_IDLE;
         left_q <= 11'h000;
         in_batch_q <= 11'h000;
         use_alt_q <= 1'b0;
         burst_flag_q <= 1'b0;
      end else begin
         unique case (state_q)
            dma_ctl_pkg::ST_IDLE: begin
               if (enable_q && mode_valid && start_req) begin
                  left_q <= {1'b0, count_field} + 11'h001;
                  in_batch_q <= batch_size;
                  state_q <= dma_ctl_pkg::ST_MOVE;
               end
            end
            dma_ctl_pkg::ST_WAIT_REQ: begin
               // basic mode stalls here until the pin asks again
               if (!mode_valid) state_q <= dma_ctl_pkg::ST_IDLE;
               else if (req_rise) begin
                  in_batch_q <= batch_size;
                  state_q <= dma_ctl_pkg::ST_MOVE;
               end
            end
            dma_ctl_pkg::ST_MOVE: begin
               left_q <= left_q - 11'h001;
               in_batch_q <= in_batch_q - 11'h001;
               if (burst_sel && is_per_sg && last_piece) burst_flag_q <= 1'b1;
               if (batch_end) state_q <= dma_ctl_pkg::ST_WRITE_BACK;
            end
            dma_ctl_pkg::ST_WRITE_BACK: begin
               // count already stored; decide whether another batch follows
               if (left_q == 11'h000) state_q <= dma_ctl_pkg::ST_DONE;
               else if (cur_mode == dma_ctl_pkg::MODE_BASIC) state_q <= dma_ctl_pkg::ST_WAIT_REQ;
               else begin
                  in_batch_q <= batch_size;
                  state_q <= dma_ctl_pkg::ST_MOVE;
               end
            end
            dma_ctl_pkg::ST_DONE: begin
               burst_flag_q <= 1'b0;
               if (cur_mode == dma_ctl_pkg::MODE_PING_PONG) begin
                  use_alt_q <= ~use_alt_q;
               end
               state_q <= dma_ctl_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // control words; engine write-back beats a software write
   // ---------------------------------------------------------------
   wire logic wb_now = batch_end;
   wire logic [31:0] wb_word = {cur_ctl[31:`COUNT_MSB+1], wb_count, cur_ctl[`COUNT_LSB-1:0]};
   // stopped at completion so a stale word cannot restart; ping-pong relies on it
   wire logic [31:0] done_word = {cur_ctl[31:`MODE_MSB+1], 3'h0};
   wire logic done_now = state_q == dma_ctl_pkg::ST_DONE;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ctl_q[0] <= `CTL_RESET;
         ctl_q[1] <= `CTL_RESET;
      end else begin
         if (wr_pri) ctl_q[0] <= reg_wdata_i;
         if (wr_alt) ctl_q[1] <= reg_wdata_i;
         if (wb_now) ctl_q[use_alt_q] <= wb_word;
         if (done_now) ctl_q[use_alt_q] <= done_word;
      end
   end

   // channel control: bit0 enable, bit1 software request pulse
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         enable_q <= 1'b0;
         soft_req_q <= 1'b0;
      end else begin
         if (wr_chan) enable_q <= reg_wdata_i[0];
         soft_req_q <= wr_chan & reg_wdata_i[1];
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   wire logic [31:0] status_word = {26'h0, use_alt_q, burst_flag_q, 1'b0,
      3'(state_q)};
   wire logic [31:0] rd_mux =
      reg_addr_i == `OFS_PRI_CTL ? ctl_q[0] :
      reg_addr_i == `OFS_ALT_CTL ? ctl_q[1] :
      reg_addr_i == `OFS_CHAN_CTL ? {31'h0, enable_q} :
      reg_addr_i == `OFS_STATUS ? status_word :
      reg_addr_i == `OFS_COUNT ? {21'h0, left_q} : 32'h0;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) rdata_q <= 32'h0;
      else rdata_q <= reg_read_i ? rd_mux : 32'h0;
   end
   assign reg_rdata_o = rdata_q;

   // transfer outputs; burst moves until a short remainder, then single unless burst select in peripheral gather or the flag is up
   assign item_move_o = moving;
   assign burst_move_o = moving & (~last_piece | burst_flag_q |
      (burst_sel & is_per_sg));
   assign burst_only_flag_o = burst_flag_q;
   assign cycle_done_o = done_now;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_stop_no_move: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_q == dma_ctl_pkg::ST_IDLE && !mode_valid) |=> !item_move_o)
      else $error("transfer started from stopped mode");
   // stored field checked against the count left after the batch, not the write-back wire
   a_wb_count: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      wb_now && !done_now |=>
      ctl_q[$past(use_alt_q)][`COUNT_MSB:`COUNT_LSB] == 10'(left_q - 11'h001))
      else $error("count not written back");
   a_cycle_end: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      cycle_end |-> ##2 cycle_done_o)
      else $error("cycle did not end");
   a_basic_wait: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_q == dma_ctl_pkg::ST_WAIT_REQ && !req_rise) |=> !item_move_o)
      else $error("basic mode moved without request");
   a_auto_go: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_q == dma_ctl_pkg::ST_WRITE_BACK && left_q != 11'h0 &&
      cur_mode == dma_ctl_pkg::MODE_AUTO) |=> item_move_o)
      else $error("auto mode stalled");
   a_ping_swap: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (done_now && cur_mode == dma_ctl_pkg::MODE_PING_PONG) |=> use_alt_q != $past(use_alt_q))
      else $error("ping-pong did not swap");
   a_single_tail: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (moving && last_piece && !burst_sel && !burst_flag_q) |-> !burst_move_o)
      else $error("tail not single");
   a_burst_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (moving && burst_sel && is_per_sg && last_piece) |=> burst_only_flag_o)
      else $error("burst flag not set");
   a_batch_len: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (arb_code >= 4'ha) |-> batch_size == 11'h400)
      else $error("batch size wrong");
   c_basic: cover property (@(posedge clk_i) state_q == dma_ctl_pkg::ST_WAIT_REQ);
   c_swap: cover property (@(posedge clk_i) use_alt_q);
   c_done: cover property (@(posedge clk_i) cycle_done_o);
   c_burst: cover property (@(posedge clk_i) burst_only_flag_o);
endmodule // dma_channel_control_word

// File: dma_channel_control_word_test.sv
// self-checking bench for the dma channel control word engine
`timescale 1ns/10ps
module dma_channel_control_word_test;
   logic clk_i, reset_n_i, reg_write_i, reg_read_i, fire, dma_request_i;
   logic [3:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, seed, rd;
   logic item_move_o, burst_move_o, burst_only_flag_o, cycle_done_o;
   logic last_burst, flag_seen, prev_move;
   int bad_count, cmp_count, moves, runs, dones;
   dma_channel_control_word uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
      .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .dma_request_i(dma_request_i),
      .item_move_o(item_move_o), .burst_move_o(burst_move_o),
      .burst_only_flag_o(burst_only_flag_o), .cycle_done_o(cycle_done_o));
   req_source far (.clk_i(clk_i), .fire_i(fire), .request_o(dma_request_i));
   // ---------------------------------------------------------------
   // clock and monitor
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // sample on the falling edge, where the move strobes are settled
   always @(negedge clk_i) begin
      if (item_move_o === 1'b1) begin
         moves++;
         last_burst = burst_move_o;
         if (prev_move !== 1'b1) runs++;
      end
      if (burst_only_flag_o === 1'b1) flag_seen = 1'b1;
      if (cycle_done_o === 1'b1) dones++;
      prev_move = item_move_o;
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic end_of_test;
      if (bad_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clk_i);
      reg_write_i <= 1'b0;
      // one idle edge so back-to-back calls never drive the strobe twice at once
      @(posedge clk_i);
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clk_i);
      reg_read_i <= 1'b0;
      #1 d = reg_rdata_o;
      @(posedge clk_i);
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // batch size is a power of two, saturating at 1024
   function automatic int batch(input logic [3:0] code);
      return (code >= 4'ha) ? 1024 : (1 << code);
   endfunction
   // one whole cycle: program, start, wait, compare counts
   task automatic run(input logic [3:0] ofs, input dma_ctl_pkg::cycle_mode_e mode,
                      input logic [3:0] code, input logic [9:0] cnt, input logic bsel);
      int items;
      int b;
      items = (mode == dma_ctl_pkg::MODE_STOP) ? 0 : cnt + 1;
      b = batch(code);
      moves = 0; runs = 0; dones = 0; flag_seen = 1'b0;
      wr(ofs, 32'h0);
      wr(ofs, {14'h0, code, cnt, bsel, mode});
      wr(4'h2, (mode == dma_ctl_pkg::MODE_BASIC) ? 32'h1 : 32'h3);
      for (int i = 0; i < 3000 && dones == 0; i++) begin
         fire <= (mode == dma_ctl_pkg::MODE_BASIC) && (i % 40 == 0);
         if (mode == dma_ctl_pkg::MODE_BASIC && i == 39 && items > b) begin
            check(moves, b);
            rd_reg(ofs, rd);
            check(rd[13:4], items - b - 1);
         end
         @(posedge clk_i);
      end
      fire <= 1'b0;
      repeat (3) @(posedge clk_i);
      check(moves, items);
      check(runs, (items + b - 1) / b);
      check(dones, (items > 0) ? 1 : 0);
      rd_reg(ofs, rd);
      check(rd[2:0], 3'h0);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      reset_n_i = 1'b0; reg_write_i = 1'b0; reg_read_i = 1'b0; fire = 1'b0;
      reg_addr_i = 4'h0; reg_wdata_i = 32'h0; seed = 32'h0000_0060;
      bad_count = 0; cmp_count = 0; prev_move = 1'b0; last_burst = 1'b0;
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      rd_reg(4'h0, rd);
      check(rd, 32'h0);
      rd_reg(4'hf, rd);
      check(rd, 32'h0);
      run(4'h0, dma_ctl_pkg::MODE_STOP, 4'h0, 10'h005, 1'b0);
      run(4'h0, dma_ctl_pkg::MODE_AUTO, 4'h9, 10'h3ff, 1'b0);
      run(4'h0, dma_ctl_pkg::MODE_AUTO, 4'ha, 10'h3ff, 1'b0);
      run(4'h0, dma_ctl_pkg::MODE_AUTO, 4'h0, 10'h000, 1'b0);
      for (int c = 0; c < 16; c++) begin
         seed = xs(seed);
         run(4'h0, dma_ctl_pkg::MODE_AUTO, c[3:0], seed[9:0], 1'b0);
      end
      run(4'h0, dma_ctl_pkg::MODE_BASIC, 4'h1, 10'h005, 1'b0);
      run(4'h0, dma_ctl_pkg::MODE_PER_SG, 4'h2, 10'h001, 1'b1);
      check(last_burst, 1'b1);
      check(flag_seen, 1'b1);
      // the alternate gather code must take the burst path as well
      run(4'h0, dma_ctl_pkg::MODE_ALT_PER_SG, 4'h2, 10'h001, 1'b1);
      check(last_burst, 1'b1);
      check(flag_seen, 1'b1);
      run(4'h0, dma_ctl_pkg::MODE_PER_SG, 4'h2, 10'h001, 1'b0);
      check(last_burst, 1'b0);
      check(flag_seen, 1'b0);
      wr(4'h1, {14'h0, 4'h0, 10'h002, 1'b0, dma_ctl_pkg::MODE_AUTO});
      run(4'h0, dma_ctl_pkg::MODE_PING_PONG, 4'h0, 10'h001, 1'b0);
      rd_reg(4'h3, rd);
      check(rd[5], 1'b1);
      rd_reg(4'h4, rd);
      check(rd, 32'h0);
      run(4'h1, dma_ctl_pkg::MODE_AUTO, 4'h0, 10'h002, 1'b0);
      end_of_test();
   end
   // watchdog: a little above the worst sum of all runs (26 runs, each capped near 3000 cycles), still far below the cycle budget
   initial begin
      repeat (90000) @(posedge clk_i);
      bad_count++;
      end_of_test();
   end
endmodule // dma_channel_control_word_test

// File: dma_ctl_cfg.svh
// constants for the per-channel control word engine
`ifndef DMA_CTL_CFG_SVH
`define DMA_CTL_CFG_SVH
// ---------------------------------------------------------------
// control word field positions
// ---------------------------------------------------------------
`define MODE_LSB 0
`define MODE_MSB 2
`define BURST_SEL_BIT 3
`define COUNT_LSB 4
`define COUNT_MSB 13
`define ARB_LSB 14
`define ARB_MSB 17
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_PRI_CTL 4'h0
`define OFS_ALT_CTL 4'h1
`define OFS_CHAN_CTL 4'h2
`define OFS_STATUS 4'h3
`define OFS_COUNT 4'h4
// ---------------------------------------------------------------
// values
// ---------------------------------------------------------------
`define CTL_RESET 32'h0000_0000
`define ARB_CODE_MAX 4'h9
`define ARB_LOG_MAX 4'ha
`endif

// File: dma_ctl_pkg.sv
// types for the per-channel control word engine
package dma_ctl_pkg;
   typedef enum logic [2:0] {
      MODE_STOP = 3'h0, MODE_BASIC = 3'h1, MODE_AUTO = 3'h2, MODE_PING_PONG = 3'h3,
      MODE_MEM_SG = 3'h4, MODE_ALT_MEM_SG = 3'h5, MODE_PER_SG = 3'h6,
      MODE_ALT_PER_SG = 3'h7
   } cycle_mode_e;
   typedef enum {ST_IDLE, ST_WAIT_REQ, ST_MOVE, ST_WRITE_BACK, ST_DONE} engine_state_e;
endpackage

// File: req_source.sv
// far-side model: a requesting peripheral driving the request pin
`timescale 1ns/10ps
module req_source (
   // clock
   input wire logic clk_i,
   // command from the bench
   input wire logic fire_i,
   // request pin
   output logic request_o
);
   logic [2:0] hold_q;
   initial hold_q = 3'h0;
   // stretch each request so it survives the two-flop synchroniser
   always @(posedge clk_i) begin
      if (fire_i) hold_q <= 3'h4;
      else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
   end
   assign request_o = (hold_q != 3'h0);
endmodule // req_source
